/* pkg/pics_pkg.sv */
package pics_pkg;
  // ---------------------------------------------------------------------
  // Register map (printed offsets are indices; byte address = 4 * index)
  // ---------------------------------------------------------------------
  localparam logic [7:0]  IDX_CHANGE_IRQ  = 8'h15;
  localparam logic [7:0]  IDX_RX_ERR_CNT  = 8'h16;
  localparam logic [7:0]  IDX_DISC_CNT    = 8'h17;
  localparam logic [7:0]  IDX_STRAP_CAP   = 8'h18;
  localparam logic [7:0]  IDX_EVT_STATUS  = 8'h20;
  localparam logic [7:0]  IDX_EVT_MASK    = 8'h21;

  // Bit positions in the change interrupt register
  localparam int BIT_PENDING   = 15;
  localparam int BIT_DPX_MASK  = 11;
  localparam int BIT_SPEED_IRQ_MASK  = 10;
  localparam int BIT_LINK_MASK = 9;
  localparam int BIT_MSTR_MASK = 8;
  localparam int BIT_DPX_CHG   = 4;
  localparam int BIT_SPD_CHG   = 3;
  localparam int BIT_LINK_CHG  = 2;
  localparam int BIT_STATUS    = 0;

  // Reset values
  localparam logic [3:0]  RST_IRQ_MASKS = 4'hF;
  localparam logic [15:0] RST_COUNT     = 16'h0000;
  localparam logic [2:0]  RST_EVT       = 3'h0;

  // AXI response codes
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Pins sampled at reset release
  typedef struct packed {
    logic       txClk;
    logic       cableState;
    logic       collision;
    logic       rxClk;
    logic       rxDataValid;
    logic       rxError;
    logic       linkIndicator;
    logic       speedIndicator;
    logic       duplexIndicator;
    logic       carrierSense;
    logic [3:0] rxData;
  } pics_strap_t;

  // Line state reported by the transceiver core
  typedef struct packed {
    logic link;
    logic speed;
    logic duplex;
  } pics_line_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
  } pics_axi_out_t;

  typedef struct packed {
    pics_line_t    lineSync1;
    pics_line_t    lineSync2;
    pics_line_t    linePrev;
    logic          rxErrSync1;
    logic          rxErrSync2;
    logic          rxErrPrev;
    logic          discSync1;
    logic          discSync2;
    logic          discPrev;
    pics_strap_t   strapSync1;
    pics_strap_t   strapSync2;
    pics_strap_t   strapCap;
    logic          strapTaken;
    logic          dpxMask;
    logic          spdMask;
    logic          linkMask;
    logic          mstrMask;
    logic          dpxChg;
    logic          spdChg;
    logic          linkChg;
    logic          irqStatus;
    logic [15:0]   rxErrCnt;
    logic [7:0]    discCnt;
    logic [2:0]    evtStatus;
    logic [2:0]    evtMask;
    logic          irqEvt;
    logic          irqOutN;
    logic          awHeld;
    logic          wHeld;
    logic [7:0]    awIdx;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    pics_axi_out_t axi;
  } pics_state_t;
endpackage

/* rtl/pics_regs.sv */
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// - Master mask set: no mgmtIrqOutN interrupt and no interrupt status ever; irqEvent is not masked.
// - Duplex change sets a sticky flag; a register read clears it.
// - Speed change sets a sticky flag; a register read clears it.
// - Link change sets a sticky flag; a register read clears it.
// - Status set when master mask clear and unmasked flag set; read clears.
// - Link mask set: link change gives no interrupt.
// - 16-bit receive error counter, reset zero, counts each error event.
// - 8-bit disconnect counter in low bits, upper bits read zero.
// - Reset captures transmit clock pin to bit 13, cable state to 12.
// - Reset captures collision, rx clock, rx valid, rx error to 11..8.
// - Reset captures link, speed, duplex indicator pins to bits 7..5.
// - Reset captures carrier sense and rx data 3..0 to bits 4..0.
// - Pending bit mirrors status bit and clears on the same read.
// - Duplex mask set: duplex change gives no interrupt.
// - Speed mask set: speed change gives no interrupt.
module pics_regs (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire pics_pkg::pics_line_t  lineState,
  input  wire logic                  rxErrorEvent,
  input  wire logic                  cableDisconnect,
  input  wire pics_pkg::pics_strap_t strapPins,
  input  wire logic [9:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [9:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       mgmtIrqOutN,
  output logic                       irqEvent
);

  pics_pkg::pics_state_t st;
  pics_pkg::pics_state_t next_st;

  logic [15:0] chgWord;
  logic [15:0] strapWord;
  logic [7:0]  rdIdx;
  logic        rdChg;
  logic        rdTake;
  logic        wrTake;
  logic [15:0] wLow;
  logic        setLink;
  logic        setSpd;
  logic        setDpx;
  logic        rxErrPulse;
  logic        discPulse;
  logic        statusNext;

  // ---------------------------------------------------------------------
  // Read views
  // ---------------------------------------------------------------------
  // Change interrupt register image
  always_comb begin
    chgWord = 16'h0000;
    chgWord[pics_pkg::BIT_PENDING]   = st.irqStatus;
    chgWord[pics_pkg::BIT_DPX_MASK]  = st.dpxMask;
    chgWord[pics_pkg::BIT_SPEED_IRQ_MASK]  = st.spdMask;
    chgWord[pics_pkg::BIT_LINK_MASK] = st.linkMask;
    chgWord[pics_pkg::BIT_MSTR_MASK] = st.mstrMask;
    chgWord[pics_pkg::BIT_DPX_CHG]   = st.dpxChg;
    chgWord[pics_pkg::BIT_SPD_CHG]   = st.spdChg;
    chgWord[pics_pkg::BIT_LINK_CHG]  = st.linkChg;
    chgWord[pics_pkg::BIT_STATUS]    = st.irqStatus;
  end

  // Captured strap layout, bits 15..14 zero
  assign strapWord = {2'h0, st.strapCap};

  // Handshake terms
  assign rdIdx  = s_axi_araddr[9:2];
  assign rdTake = s_axi_arvalid && st.axi.arready;
  assign rdChg  = rdTake && (rdIdx == pics_pkg::IDX_CHANGE_IRQ);
  assign wrTake = st.awHeld && st.wHeld && !st.axi.bvalid;
  assign wLow   = st.wStrb[1:0] == 2'h3 ? st.wData[15:0] : 16'h0000;

  // Edge detection on synchronised inputs
  assign setLink    = st.lineSync2.link   != st.linePrev.link;
  assign setSpd     = st.lineSync2.speed  != st.linePrev.speed;
  assign setDpx     = st.lineSync2.duplex != st.linePrev.duplex;
  assign rxErrPulse = st.rxErrSync2 && !st.rxErrPrev;
  assign discPulse  = st.discSync2 && !st.discPrev;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Two-flop synchronisers for pins
    next_st.lineSync1  = lineState;
    next_st.lineSync2  = st.lineSync1;
    next_st.linePrev   = st.lineSync2;
    next_st.rxErrSync1 = rxErrorEvent;
    next_st.rxErrSync2 = st.rxErrSync1;
    next_st.rxErrPrev  = st.rxErrSync2;
    next_st.discSync1  = cableDisconnect;
    next_st.discSync2  = st.discSync1;
    next_st.discPrev   = st.discSync2;
    next_st.strapSync1 = strapPins;
    next_st.strapSync2 = st.strapSync1;

    // Strap capture once, just after reset release
    if (!st.strapTaken) begin
      next_st.strapCap   = st.strapSync2;
      next_st.strapTaken = 1'b1;
    end

    // Sticky change flags, set wins over read clear
    if (rdChg) begin
      next_st.linkChg = 1'b0;
      next_st.spdChg  = 1'b0;
      next_st.dpxChg  = 1'b0;
    end
    if (setLink) next_st.linkChg = 1'b1;
    if (setSpd)  next_st.spdChg  = 1'b1;
    if (setDpx)  next_st.dpxChg  = 1'b1;

    // Counters wrap and ignore writes
    if (rxErrPulse) next_st.rxErrCnt = st.rxErrCnt + 16'h0001;
    if (discPulse)  next_st.discCnt  = st.discCnt + 8'h01;

    // Wrapper event status, write one to clear
    next_st.evtStatus = st.evtStatus | {setDpx, setSpd, setLink};

    // AXI write channel capture
    if (s_axi_awvalid && st.axi.awready) begin
      next_st.awHeld      = 1'b1;
      next_st.awIdx       = s_axi_awaddr[9:2];
      next_st.axi.awready = 1'b0;
    end
    if (s_axi_wvalid && st.axi.wready) begin
      next_st.wHeld      = 1'b1;
      next_st.wData      = s_axi_wdata;
      next_st.wStrb      = s_axi_wstrb;
      next_st.axi.wready = 1'b0;
    end
    if (wrTake) begin
      next_st.awHeld     = 1'b0;
      next_st.wHeld      = 1'b0;
      next_st.axi.bvalid = 1'b1;
      next_st.axi.bresp  = pics_pkg::RESP_OKAY;
      unique case (st.awIdx)
        pics_pkg::IDX_CHANGE_IRQ: begin
          if (st.wStrb[1]) begin
            next_st.dpxMask  = st.wData[pics_pkg::BIT_DPX_MASK];
            next_st.spdMask  = st.wData[pics_pkg::BIT_SPEED_IRQ_MASK];
            next_st.linkMask = st.wData[pics_pkg::BIT_LINK_MASK];
            next_st.mstrMask = st.wData[pics_pkg::BIT_MSTR_MASK];
          end
        end
        pics_pkg::IDX_RX_ERR_CNT, pics_pkg::IDX_DISC_CNT,
        pics_pkg::IDX_STRAP_CAP: begin
          next_st.axi.bresp = pics_pkg::RESP_OKAY;
        end
        pics_pkg::IDX_EVT_STATUS: begin
          next_st.evtStatus = (st.evtStatus & ~wLow[2:0])
                            | {setDpx, setSpd, setLink};
        end
        pics_pkg::IDX_EVT_MASK: begin
          next_st.evtMask = wLow[2:0];
        end
        default: next_st.axi.bresp = pics_pkg::RESP_SLVERR;
      endcase
    end
    if (st.axi.bvalid && s_axi_bready) begin
      next_st.axi.bvalid  = 1'b0;
      next_st.axi.awready = 1'b1;
      next_st.axi.wready  = 1'b1;
    end

    // AXI read channel
    if (rdTake) begin
      next_st.axi.arready = 1'b0;
      next_st.axi.rvalid  = 1'b1;
      next_st.axi.rresp   = pics_pkg::RESP_OKAY;
      unique case (rdIdx)
        pics_pkg::IDX_CHANGE_IRQ: next_st.axi.rdata = {16'h0000, chgWord};
        pics_pkg::IDX_RX_ERR_CNT: next_st.axi.rdata = {16'h0000, st.rxErrCnt};
        pics_pkg::IDX_DISC_CNT:   next_st.axi.rdata = {24'h00_0000, st.discCnt};
        pics_pkg::IDX_STRAP_CAP:  next_st.axi.rdata = {16'h0000, strapWord};
        pics_pkg::IDX_EVT_STATUS: next_st.axi.rdata = {29'h0, st.evtStatus};
        pics_pkg::IDX_EVT_MASK:   next_st.axi.rdata = {29'h0, st.evtMask};
        default: begin
          next_st.axi.rdata = 32'h0000_0000;
          next_st.axi.rresp = pics_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st.axi.rvalid && s_axi_rready) begin
      next_st.axi.rvalid  = 1'b0;
      next_st.axi.arready = 1'b1;
    end

    // Interrupt status from the flags that will stand next cycle
    statusNext = !next_st.mstrMask
               && ((next_st.linkChg && !next_st.linkMask)
                || (next_st.spdChg  && !next_st.spdMask)
                || (next_st.dpxChg  && !next_st.dpxMask));
    next_st.irqStatus = statusNext;
    next_st.irqOutN   = !statusNext;
    next_st.irqEvt    = |(next_st.evtStatus & next_st.evtMask);
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st             <= '0;
      st.dpxMask     <= pics_pkg::RST_IRQ_MASKS[3];
      st.spdMask     <= pics_pkg::RST_IRQ_MASKS[2];
      st.linkMask    <= pics_pkg::RST_IRQ_MASKS[1];
      st.mstrMask    <= pics_pkg::RST_IRQ_MASKS[0];
      st.rxErrCnt    <= pics_pkg::RST_COUNT;
      st.evtStatus   <= pics_pkg::RST_EVT;
      st.irqOutN     <= 1'b1;
      st.axi.awready <= 1'b1;
      st.axi.wready  <= 1'b1;
      st.axi.arready <= 1'b1;
      // Synchronisers run through reset: settled straps, no false edge
      st.lineSync1   <= next_st.lineSync1;
      st.lineSync2   <= next_st.lineSync2;
      st.linePrev    <= next_st.linePrev;
      st.rxErrSync1  <= next_st.rxErrSync1;
      st.rxErrSync2  <= next_st.rxErrSync2;
      st.rxErrPrev   <= next_st.rxErrPrev;
      st.discSync1   <= next_st.discSync1;
      st.discSync2   <= next_st.discSync2;
      st.discPrev    <= next_st.discPrev;
      st.strapSync1  <= next_st.strapSync1;
      st.strapSync2  <= next_st.strapSync2;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = st.axi.awready;
  assign s_axi_wready  = st.axi.wready;
  assign s_axi_bresp   = st.axi.bresp;
  assign s_axi_bvalid  = st.axi.bvalid;
  assign s_axi_arready = st.axi.arready;
  assign s_axi_rdata   = st.axi.rdata;
  assign s_axi_rresp   = st.axi.rresp;
  assign s_axi_rvalid  = st.axi.rvalid;
  assign mgmtIrqOutN   = st.irqOutN;
  assign irqEvent      = st.irqEvt;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  sequence s_link_edge;
    setLink && !st.linkMask && !st.mstrMask;
  endsequence

  a_master_mask_quiet: assert property (
    @(posedge core_clk) disable iff (reset)
    st.mstrMask |-> (st.irqOutN && !st.irqStatus))
    else $error("irq under master mask");
  a_duplex_flag_set: assert property (
    @(posedge core_clk) disable iff (reset)
    setDpx |=> st.dpxChg)
    else $error("duplex flag not set");
  a_speed_flag_set: assert property (
    @(posedge core_clk) disable iff (reset)
    setSpd |=> st.spdChg)
    else $error("speed flag not set");
  a_link_flag_clear: assert property (
    @(posedge core_clk) disable iff (reset)
    rdChg && !setLink |=> !st.linkChg)
    else $error("link flag not cleared");
  a_link_irq_path: assert property (
    @(posedge core_clk) disable iff (reset)
    s_link_edge ##1 (!st.mstrMask && !st.linkMask) |-> !st.irqOutN)
    else $error("link change gave no interrupt");
  a_link_mask_hold: assert property (
    @(posedge core_clk) disable iff (reset)
    st.linkMask && !st.spdChg && !st.dpxChg |-> !st.irqStatus)
    else $error("masked link raised status");
  a_rx_err_count: assert property (
    @(posedge core_clk) disable iff (reset)
    rxErrPulse |=> st.rxErrCnt == $past(st.rxErrCnt) + 16'h0001)
    else $error("rx error count wrong");
  a_disc_count: assert property (
    @(posedge core_clk) disable iff (reset)
    !discPulse |=> st.discCnt == $past(st.discCnt))
    else $error("disc count moved");
  a_strap_stable: assert property (
    @(posedge core_clk) disable iff (reset)
    st.strapTaken ##1 st.strapTaken |-> $stable(st.strapCap))
    else $error("strap capture changed");
  a_pending_mirror: assert property (
    @(posedge core_clk) disable iff (reset)
    st.axi.rvalid && $past(rdChg) |-> st.axi.rdata[15] == st.axi.rdata[0])
    else $error("pending differs from status");
  a_duplex_mask_hold: assert property (
    @(posedge core_clk) disable iff (reset)
    st.dpxMask && !st.linkChg && !st.spdChg |-> !st.irqStatus)
    else $error("masked duplex raised status");
  a_speed_mask_hold: assert property (
    @(posedge core_clk) disable iff (reset)
    st.spdMask && !st.linkChg && !st.dpxChg |-> !st.irqStatus)
    else $error("masked speed raised status");
  a_out_matches: assert property (
    @(posedge core_clk) disable iff (reset)
    st.irqOutN == !st.irqStatus)
    else $error("output not active low");
  a_out_low_flag: assert property (
    @(posedge core_clk) disable iff (reset)
    !st.mstrMask && ((st.linkChg && !st.linkMask)
      || (st.spdChg && !st.spdMask) || (st.dpxChg && !st.dpxMask))
    |-> !st.irqOutN)
    else $error("output not low while flag set");

endmodule

/* sim/pics_phy_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Transceiver core stand-in: line state levels and event pulses
// ------------------------------------------------------------------
module pics_phy_model (
  input  wire logic            core_clk,
  output pics_pkg::pics_line_t lineState,
  output logic                 rxErrorEvent,
  output logic                 cableDisconnect
);
  // Quiet levels from time zero
  initial begin
    lineState = '0;
    rxErrorEvent = 1'h0;
    cableDisconnect = 1'h0;
  end

  // Flip one line level: 2 link, 1 speed, 0 duplex; room for sync
  task automatic flip(input int i);
    @(posedge core_clk);
    lineState[i] <= ~lineState[i];
    repeat (6) @(posedge core_clk);
  endtask

  // One rising edge: 0 receive error, 1 disconnect
  task automatic pulse(input int i);
    @(posedge core_clk);
    if (i == 0) rxErrorEvent <= 1'h1;
    else cableDisconnect <= 1'h1;
    repeat (3) @(posedge core_clk);
    rxErrorEvent <= 1'h0;
    cableDisconnect <= 1'h0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // Addresses, signals, reference model
  // ----------------------------------------------------------------
  localparam logic [9:0] A_CHG = {pics_pkg::IDX_CHANGE_IRQ, 2'h0};
  localparam logic [9:0] A_RXE = {pics_pkg::IDX_RX_ERR_CNT, 2'h0};
  localparam logic [9:0] A_DSC = {pics_pkg::IDX_DISC_CNT, 2'h0};
  localparam logic [9:0] A_STR = {pics_pkg::IDX_STRAP_CAP, 2'h0};
  localparam logic [9:0] A_EVS = {pics_pkg::IDX_EVT_STATUS, 2'h0};
  localparam logic [9:0] A_EVM = {pics_pkg::IDX_EVT_MASK, 2'h0};
  localparam logic [1:0] OK    = pics_pkg::RESP_OKAY;
  localparam logic [1:0] ERR   = pics_pkg::RESP_SLVERR;
  logic                  core_clk, reset, rxErrorEvent, cableDisconnect;
  pics_pkg::pics_line_t  lineState;
  pics_pkg::pics_strap_t strapPins;
  logic [9:0]            awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb, msk;
  logic [1:0]            bresp, rresp;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic                  mgmtIrqOutN, irqEvent;
  logic [2:0]            flg, evt, evtMsk;
  int                    bad_count, cmp_count, rxCnt, dcCnt, n;

  // Clock, 50 ns period
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end

  pics_phy_model u_phy (.core_clk(core_clk), .lineState(lineState),
    .rxErrorEvent(rxErrorEvent), .cableDisconnect(cableDisconnect));
  pics_regs u_dut (.core_clk(core_clk), .reset(reset),
    .lineState(lineState), .rxErrorEvent(rxErrorEvent),
    .cableDisconnect(cableDisconnect), .strapPins(strapPins),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mgmtIrqOutN(mgmtIrqOutN),
    .irqEvent(irqEvent));

  // Expected status and change register word
  function automatic logic irq_st();
    return !msk[0] && |(flg & ~msk[3:1]);
  endfunction
  function automatic logic [31:0] exp_chg();
    return {16'h0000, irq_st(), 3'h0, msk, 3'h0, flg, 1'h0, irq_st()};
  endfunction

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [31:0] g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %b", $time, m, g);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tmo(inout int c);
    c++;
    if (c > 50) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  // Handshakes sampled on the falling edge, acted on at the rising one
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int   c;
    logic ta, tw, tb;
    c = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(negedge core_clk);
      tmo(c);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge core_clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
    end while (!tb);
  endtask
  task automatic axi_rd(input logic [9:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int   c;
    logic ta, tr;
    c = 0;
    @(posedge core_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(negedge core_clk);
      tmo(c);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ta) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
    end while (!tr);
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_word(d, e, "read data");
    chk_word(32'(r), 32'(er), "read resp");
  endtask
  task automatic wr_chk(input logic [9:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_word(32'(r), 32'(er), "write resp");
  endtask
  task automatic rd_chg();
    rd_chk(A_CHG, exp_chg(), OK);
    flg = 3'h0;
  endtask
  // Line change on source j: 0 link, 1 speed, 2 duplex
  task automatic hit(input int j);
    u_phy.flip(2 - j);
    flg[j] = 1'h1;
    evt[j] = 1'h1;
    @(negedge core_clk);
    chk_bit(mgmtIrqOutN, !irq_st(), "irq pin");
    chk_bit(irqEvent, |(evt & evtMsk), "event irq");
  endtask

  // ----------------------------------------------------------------
  // Test sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h80db_a6f1));
    strapPins = pics_pkg::pics_strap_t'(14'($urandom()));
    reset = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {flg, evt, evtMsk} = '0;
    msk = 4'hF;
    repeat (6) @(posedge core_clk);
    reset <= 1'h0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk_bit(mgmtIrqOutN, 1'h1, "irq idle");
    rd_chg();
    rd_chk(A_RXE, 32'h0000_0000, OK);
    rd_chk(A_DSC, 32'h0000_0000, OK);
    rd_chk(A_STR, 32'(strapPins), OK);
    $display("test reset_values done");
    // One mask per pass, last pass the master mask
    for (int j = 0; j < 4; j++) begin
      msk = 4'h1 << ((j + 1) % 4);
      wr_chk(A_CHG, {20'h0_0000, msk, 8'h00}, OK);
      hit(j % 3);
      hit((j + 1) % 3);
      rd_chg();
      rd_chg();
      @(negedge core_clk);
      chk_bit(mgmtIrqOutN, 1'h1, "irq after read");
    end
    $display("test change_masks done");
    wr_chk(A_EVS, 32'h0000_0007, OK);
    evt = 3'h0;
    wr_chk(A_EVM, 32'h0000_0002, OK);
    evtMsk = 3'h2;
    hit(0);
    hit(1);
    rd_chk(A_EVS, 32'(evt), OK);
    wr_chk(A_EVS, 32'h0000_0002, OK);
    evt[1] = 1'h0;
    @(negedge core_clk);
    chk_bit(irqEvent, 1'h0, "event irq cleared");
    rd_chk(A_EVM, 32'h0000_0002, OK);
    $display("test event_irq done");
    n = 1 + $urandom_range(5);
    repeat (n) u_phy.pulse(0);
    rxCnt = n;
    n = 254 + $urandom_range(4);
    repeat (n) u_phy.pulse(1);
    dcCnt = n % 256;
    for (int k = 0; k < 2; k++) begin
      rd_chk(A_RXE, 32'(rxCnt), OK);
      rd_chk(A_DSC, 32'(dcCnt), OK);
      wr_chk(A_RXE, 32'hFFFF_FFFF, OK);
      wr_chk(A_DSC, 32'hFFFF_FFFF, OK);
    end
    $display("test counters done");
    wr_chk(A_STR, 32'h0000_0000, OK);
    rd_chk(A_STR, 32'(strapPins), OK);
    rd_chk(10'h3F0, 32'h0000_0000, ERR);
    wr_chk(10'h3F0, 32'h0000_0001, ERR);
    $display("test unmapped done");
    report_and_stop();
  end

  initial begin
    #(50 * 20000);
    bad_count++;
    report_and_stop();
  end
endmodule
